// ===== hw/tra_ctrl.sv
// temperature result, threshold alarm and clock control register block
`timescale 1ns/100ps
`include "tra_cfg.svh"
module tra_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port from the serial link logic
    input wire tra_pkg::tra_wr_s wr_req,
    input wire logic [9:0] rd_addr,
    output logic [7:0] rd_data,
    // conversion and mission status
    input wire logic conv_valid,
    input wire tra_pkg::tra_raw_s raw,
    input wire logic mission_active,
    input wire logic log_format_select,
    input wire logic forced_conv_cmd,
    input wire logic start_mission_cmd,
    input wire logic clear_alarms,
    input wire logic [13:0] sample_rate_raw,
    // outputs to the rest of the device
    output logic oscillator_enable,
    output logic sample_unit_seconds,
    output logic [13:0] sample_rate,
    output logic high_alarm_flag,
    output logic low_alarm_flag,
    output logic [15:0] log_sample
);
    // ==========================================
    // registers
    logic [7:0] low_thr;
    logic [7:0] high_thr;
    logic high_alarm_enable;
    logic low_alarm_enable;
    tra_pkg::tra_result_s result;
    logic result_valid;
    logic high_hit;
    logic low_hit;
    logic ctrl_wr_ok;

    function automatic logic hit_addr(input logic [9:0] a, input logic [9:0] b);
        hit_addr = (a == b);
    endfunction

    // ==========================================
    // formatting and comparison
    tra_fmt u_fmt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .conv_valid(conv_valid),
        .raw(raw),
        .log_format_select(log_format_select),
        .result(result),
        .result_valid(result_valid)
    );

    tra_cmp u_cmp (
        .result_high_byte(result.high),
        .low_thr(low_thr),
        .high_thr(high_thr),
        .high_alarm_enable(high_alarm_enable),
        .low_alarm_enable(low_alarm_enable),
        .high_hit(high_hit),
        .low_hit(low_hit)
    );

    // mission locks out control writes
    assign ctrl_wr_ok = wr_req.wr && !mission_active; // RL14

    // ==========================================
    // thresholds
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_thr <= `TRA_RESET_BYTE;
            high_thr <= `TRA_RESET_BYTE;
        end else if (ctrl_wr_ok) begin
            if (hit_addr(wr_req.addr, `TRA_ADDR_LOW_THR)) begin
                low_thr <= wr_req.wdata; // RL8
            end
            if (hit_addr(wr_req.addr, `TRA_ADDR_HIGH_THR)) begin
                high_thr <= wr_req.wdata; // RL8
            end
        end
    end

    // ==========================================
    // sensor control
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            high_alarm_enable <= 1'b0;
            low_alarm_enable <= 1'b0;
        end else if (ctrl_wr_ok && hit_addr(wr_req.addr, `TRA_ADDR_SENS_CTRL)) begin
            high_alarm_enable <= wr_req.wdata[`TRA_BIT_HIGH_EN]; // RL13
            low_alarm_enable <= wr_req.wdata[`TRA_BIT_LOW_EN]; // RL13
        end
    end

    // ==========================================
    // clock control; commands win over a register write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            oscillator_enable <= 1'b0;
            sample_unit_seconds <= 1'b0;
        end else begin
            if (ctrl_wr_ok && hit_addr(wr_req.addr, `TRA_ADDR_CLK_CTRL)) begin
                oscillator_enable <= wr_req.wdata[`TRA_BIT_OSC_EN]; // RL16
                sample_unit_seconds <= wr_req.wdata[`TRA_BIT_UNIT_SEC]; // RL15
            end
            if (forced_conv_cmd || start_mission_cmd) begin
                oscillator_enable <= 1'b1; // RL17
            end
        end
    end

    // ==========================================
    // sample rate: zero behaves as one
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sample_rate <= `TRA_RATE_MIN;
        end else begin
            sample_rate <= (sample_rate_raw == 14'h0000) ? `TRA_RATE_MIN
                                                        : sample_rate_raw; // RL19
        end
    end

    // ==========================================
    // alarm flags; a hit in the clearing cycle still sets the flag
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            high_alarm_flag <= 1'b0;
            low_alarm_flag <= 1'b0;
        end else begin
            if (clear_alarms) begin
                high_alarm_flag <= 1'b0;
                low_alarm_flag <= 1'b0;
            end
            if (result_valid && mission_active && high_hit) begin
                high_alarm_flag <= 1'b1; // RL10
            end
            if (result_valid && mission_active && low_hit) begin
                low_alarm_flag <= 1'b1; // RL11
            end
        end
    end

    // ==========================================
    // log sample: high byte at the lower address, low byte only in 16-bit
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            log_sample <= '0;
        end else if (result_valid) begin
            log_sample <= result; // RL6 RL20
        end
    end

    // ==========================================
    // read mux; result bytes come from one register so they never mix
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_data <= `TRA_RESET_BYTE;
        end else begin
            case (rd_addr)
                `TRA_ADDR_LOW_THR: rd_data <= low_thr;
                `TRA_ADDR_HIGH_THR: rd_data <= high_thr;
                `TRA_ADDR_RES_LOW: rd_data <= result.low; // RL21
                `TRA_ADDR_RES_HIGH: rd_data <= result.high; // RL21
                `TRA_ADDR_SENS_CTRL: rd_data <= {6'h00, high_alarm_enable,
                                                 low_alarm_enable}; // RL13
                `TRA_ADDR_CLK_CTRL: rd_data <= {6'h00, sample_unit_seconds,
                                                oscillator_enable}; // RL13
                `TRA_ADDR_ALARM_STAT: rd_data <= `TRA_STAT_FIXED |
                                     {6'h00, high_alarm_flag, low_alarm_flag}; // RL12
                default: rd_data <= `TRA_RESET_BYTE;
            endcase
        end
    end

    // ==========================================
    // checks
    sequence s_high_hit;
        conv_valid && mission_active && high_alarm_enable && !raw.under;
    endsequence

    AST_LOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        mission_active && !forced_conv_cmd && !start_mission_cmd
        |=> $stable(oscillator_enable) && $stable(sample_unit_seconds)) // RL14
        else $error("control changed during mission");
    AST_OSC_CMD: assert property (@(posedge sys_clk) disable iff (!nrst)
        forced_conv_cmd || start_mission_cmd |=> oscillator_enable) // RL17
        else $error("command did not start oscillator");
    AST_HIGH_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
        result_valid && mission_active && high_hit |=> high_alarm_flag) // RL10
        else $error("high alarm flag missed");
    AST_LOW_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
        result_valid && mission_active && low_hit |=> low_alarm_flag) // RL11
        else $error("low alarm flag missed");
    AST_NO_HIGH: assert property (@(posedge sys_clk) disable iff (!nrst)
        !high_alarm_enable && !high_alarm_flag && !clear_alarms
        && !ctrl_wr_ok |=> !high_alarm_flag) // RL10
        else $error("high alarm while disabled");
    AST_RATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        sample_rate != 14'h0000) // RL19
        else $error("sample rate zero");
    AST_RES_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_addr == `TRA_ADDR_RES_HIGH |=> rd_data == $past(result.high)) // RL21
        else $error("result high read wrong");
    AST_CTRL_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(rd_addr) == `TRA_ADDR_CLK_CTRL |-> rd_data[7:2] == 6'h00) // RL13
        else $error("reserved control bits set");
    AST_STAT: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(rd_addr) == `TRA_ADDR_ALARM_STAT |-> rd_data[6:4] == 3'h7) // RL12
        else $error("alarm status fixed bits wrong");
    AST_HIGH_SEQ: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_high_hit ##1 (result_valid && high_hit && mission_active)
        |=> high_alarm_flag) // RL10
        else $error("high alarm sequence failed");
endmodule

// ===== hw/tra_cfg.svh
// constants for the temperature result, alarm and clock control block
// Behaviour
// RL1 - results are unsigned, 8-bit at 0.5C steps or 16-bit at 0.0625C steps
// RL2 - high byte always valid; 16-bit low byte keeps three top bits, rest zero
// RL3 - in 8-bit mode the low byte holds no defined value
// RL4 - below range gives 00h/0000h, above range gives FFh/FFE0h
// RL5 - degrees are high/2 minus variant offset plus low/512 in 16-bit mode
// RL6 - log samples and latest-result bytes share one encoding
// RL7 - host writes thresholds as one byte, twice degrees plus 82 or 2
// RL8 - low threshold lives at 0208h, high threshold at 0209h
// RL9 - alarm comparison uses the result high byte only
// RL10 - in mission, enabled high alarm sets flag when high byte >= high threshold
// RL11 - in mission, enabled low alarm sets flag when high byte <= low threshold
// RL12 - alarm flags sit in the alarm status register at 0214h
// RL13 - control register bits 2 to 7 read zero and ignore writes
// RL14 - during a mission control register writes are ignored
// RL15 - sample-unit bit selects minutes when 0, seconds when 1
// RL16 - oscillator enable bit starts or stops the clock oscillator
// RL17 - forced conversion or start mission sets the oscillator enable
// RL18 - host should stop the oscillator when the device is idle
// RL19 - sample rate is a 14-bit count; zero acts as one
// RL20 - log format bit picks 8-bit or 16-bit storage, high byte first
// RL21 - both latest-result bytes update together per conversion
`ifndef TRA_CFG_SVH
`define TRA_CFG_SVH

// ==========================================
// register addresses
`define TRA_ADDR_LOW_THR 10'h208
`define TRA_ADDR_HIGH_THR 10'h209
`define TRA_ADDR_RES_LOW 10'h20C
`define TRA_ADDR_RES_HIGH 10'h20D
`define TRA_ADDR_SENS_CTRL 10'h210
`define TRA_ADDR_CLK_CTRL 10'h212
`define TRA_ADDR_ALARM_STAT 10'h214

// ==========================================
// fields and values
`define TRA_BIT_LOW_EN 0
`define TRA_BIT_HIGH_EN 1
`define TRA_BIT_OSC_EN 0
`define TRA_BIT_UNIT_SEC 1
`define TRA_CTRL_MASK 8'h03
`define TRA_STAT_FIXED 8'h70
`define TRA_LOW_KEEP_MASK 8'hE0
`define TRA_UNDER_CODE 16'h0000
`define TRA_OVER_CODE 16'hFFE0
`define TRA_RATE_MIN 14'h0001
`define TRA_RESET_BYTE 8'h00

`endif

// ===== hw/tra_pkg.sv
// types for the temperature result, alarm and clock control block
package tra_pkg;
    typedef struct packed {
        logic [15:0] code;
        logic under;
        logic over;
    } tra_raw_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } tra_result_s;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic wr;
    } tra_wr_s;

    typedef enum logic [1:0] {
        TRA_IDLE = 2'b00,
        TRA_FMT = 2'b01,
        TRA_CMP = 2'b10
    } tra_state_e;
endpackage

// ===== hw/tra_fmt.sv
// result formatter: clamps and truncates one raw conversion
`timescale 1ns/100ps
`include "tra_cfg.svh"
module tra_fmt (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // raw conversion in
    input wire logic conv_valid,
    input wire tra_pkg::tra_raw_s raw,
    input wire logic log_format_select,
    // formatted result out
    output tra_pkg::tra_result_s result,
    output logic result_valid
);
    logic [15:0] next_code;

    always_comb begin
        next_code = raw.code & {8'hFF, `TRA_LOW_KEEP_MASK}; // RL2
        if (raw.under) begin
            next_code = `TRA_UNDER_CODE; // RL4
        end else if (raw.over) begin
            next_code = `TRA_OVER_CODE; // RL4
        end
        // 8-bit mode: low byte is undefined, we simply zero it
        if (!log_format_select) begin
            next_code[7:0] = `TRA_RESET_BYTE; // RL3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= conv_valid;
            if (conv_valid) begin
                result <= next_code; // RL1 RL5 RL6
            end
        end
    end

    AST_FMT_TRUNC: assert property (@(posedge sys_clk) disable iff (!nrst)
        result_valid |-> result.low[4:0] == 5'h00) // RL2
        else $error("low result bits not zero");
    AST_FMT_OVER: assert property (@(posedge sys_clk) disable iff (!nrst)
        conv_valid && raw.over && !raw.under |=> result.high == 8'hFF) // RL4
        else $error("over-range code wrong");
    AST_FMT_UNDER: assert property (@(posedge sys_clk) disable iff (!nrst)
        conv_valid && raw.under |=> result == 16'h0000) // RL4
        else $error("under-range code wrong");
endmodule

// ===== hw/tra_cmp.sv
// alarm comparator on the result high byte
`timescale 1ns/100ps
module tra_cmp (
    // result and thresholds
    input wire logic [7:0] result_high_byte,
    input wire logic [7:0] low_thr,
    input wire logic [7:0] high_thr,
    // enables
    input wire logic high_alarm_enable,
    input wire logic low_alarm_enable,
    // hits
    output logic high_hit,
    output logic low_hit
);
    assign high_hit = high_alarm_enable && (result_high_byte >= high_thr); // RL9 RL10
    assign low_hit = low_alarm_enable && (result_high_byte <= low_thr); // RL9 RL11
endmodule

// ===== verification/tra_host.sv
// host-side register master model for the result and alarm block
`timescale 1ns/100ps
module tra_host (
    // clock
    input wire logic sys_clk,
    // register port
    output tra_pkg::tra_wr_s wr_req,
    output logic [9:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        wr_req = '0;
        rd_addr = 10'h3FF;
    end

    // ==========================================
    // bus cycles
    // thresholds go out as whole bytes, twice the degrees plus the offset
    task automatic write(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_req <= '{addr: a, wdata: d, wr: 1'b1};
        @(posedge sys_clk);
        // released lines carry the inverse so a stale value cannot pass
        wr_req <= '{addr: ~a, wdata: ~d, wr: 1'b0};
    endtask

    task automatic read(input logic [9:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_addr <= a;
        @(posedge sys_clk);
        #1 d = rd_data;
    endtask
endmodule

// ===== verification/temp_result_alarm_rtc_ctrl_test.sv
// self-checking bench for the result, alarm and clock control block
`timescale 1ns/100ps
module temp_result_alarm_rtc_ctrl_test;
    typedef struct packed {
        logic fmt;
        logic under;
        logic over;
        logic [15:0] code;
        logic [15:0] exp;
        logic [15:0] mask;
    } tra_row_s;
    logic sys_clk, nrst, conv_valid, mission_active, log_format_select;
    logic forced_conv_cmd, start_mission_cmd, clear_alarms;
    logic oscillator_enable, sample_unit_seconds, high_alarm_flag, low_alarm_flag;
    logic [9:0] rd_addr;
    logic [7:0] rd_data, d;
    logic [13:0] sample_rate_raw, sample_rate, v;
    logic [15:0] log_sample;
    tra_pkg::tra_wr_s wr_req;
    tra_pkg::tra_raw_s raw;
    int n_mismatch, checked;
    // 8-bit rows mask off the low byte, which carries no defined value
    tra_row_s rows[7] = '{
        '{1'b1, 1'b0, 1'b0, 16'h17FF, 16'h17E0, 16'hFFFF},
        '{1'b1, 1'b0, 1'b0, 16'h5400, 16'h5400, 16'hFFFF},
        '{1'b1, 1'b1, 1'b0, 16'h1234, 16'h0000, 16'hFFFF},
        '{1'b1, 1'b0, 1'b1, 16'h1234, 16'hFFE0, 16'hFFFF},
        '{1'b0, 1'b0, 1'b0, 16'h54AB, 16'h5400, 16'hFF00},
        '{1'b0, 1'b1, 1'b0, 16'h5400, 16'h0000, 16'hFF00},
        '{1'b0, 1'b0, 1'b1, 16'h1700, 16'hFF00, 16'hFF00}};
    logic [9:0] ra[6] = '{10'h208, 10'h209, 10'h210, 10'h212, 10'h214, 10'h3FF};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00};

    tra_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .wr_req(wr_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .conv_valid(conv_valid), .raw(raw),
        .mission_active(mission_active), .log_format_select(log_format_select),
        .forced_conv_cmd(forced_conv_cmd), .start_mission_cmd(start_mission_cmd),
        .clear_alarms(clear_alarms), .sample_rate_raw(sample_rate_raw),
        .oscillator_enable(oscillator_enable), .sample_unit_seconds(sample_unit_seconds),
        .sample_rate(sample_rate), .high_alarm_flag(high_alarm_flag),
        .low_alarm_flag(low_alarm_flag), .log_sample(log_sample));
    tra_host host_u (.sys_clk(sys_clk), .wr_req(wr_req), .rd_addr(rd_addr), .rd_data(rd_data));

    // ==========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic convert(input logic f, input logic u, input logic o, input logic [15:0] c);
        @(posedge sys_clk);
        log_format_select <= f;
        conv_valid <= 1'b1;
        raw <= '{code: c, under: u, over: o};
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        raw <= '{code: ~c, under: 1'b0, over: 1'b0};
    endtask

    task automatic pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) forced_conv_cmd <= 1'b1;
        else if (which == 1) start_mission_cmd <= 1'b1;
        else clear_alarms <= 1'b1;
        @(posedge sys_clk);
        forced_conv_cmd <= 1'b0;
        start_mission_cmd <= 1'b0;
        clear_alarms <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ==========================================
    // clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        {nrst, conv_valid, mission_active, log_format_select} = 4'h0;
        {forced_conv_cmd, start_mission_cmd, clear_alarms} = 3'h0;
        raw = '0;
        sample_rate_raw = 14'h0055;
        repeat (10) @(posedge sys_clk);
        #1 check({2'h0, sample_rate}, 16'h0001);
        check({14'h0, high_alarm_flag, low_alarm_flag}, 16'h0000);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            host_u.read(ra[i], d);
            check({8'h00, d}, {8'h00, rv[i]});
        end
        for (int i = 0; i < 7; i++) begin
            convert(rows[i].fmt, rows[i].under, rows[i].over, rows[i].code);
            host_u.read(10'h20D, d);
            check({8'h00, d}, {8'h00, rows[i].exp[15:8]});
            host_u.read(10'h20C, d);
            check({8'h00, d & rows[i].mask[7:0]}, {8'h00, rows[i].exp[7:0]});
            check(log_sample & rows[i].mask, rows[i].exp);
        end
        host_u.write(10'h210, 8'hFF);
        host_u.read(10'h210, d);
        check({8'h00, d}, 16'h0003);
        host_u.write(10'h212, 8'hFE);
        host_u.write(10'h214, 8'hFF);
        host_u.read(10'h212, d);
        check({8'h00, d}, 16'h0002);
        check({14'h0, sample_unit_seconds, oscillator_enable}, 16'h0002);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0070);
        pulse(0);
        check({15'h0, oscillator_enable}, 16'h0001);
        host_u.write(10'h212, 8'h00);
        host_u.read(10'h212, d);
        check({15'h0, oscillator_enable}, 16'h0000);
        pulse(1);
        check({15'h0, oscillator_enable}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 14'h0000 : (i == 1) ? 14'h0001 : 14'h3FFF;
            @(posedge sys_clk);
            sample_rate_raw <= v;
            repeat (2) @(posedge sys_clk);
            #1 check({2'h0, sample_rate}, {2'h0, (v == 14'h0) ? 14'h0001 : v});
        end
        host_u.write(10'h208, 8'h3E);
        host_u.write(10'h209, 8'h85);
        host_u.read(10'h208, d);
        check({8'h00, d}, 16'h003E);
        host_u.read(10'h209, d);
        check({8'h00, d}, 16'h0085);
        mission_active <= 1'b1;
        convert(1'b1, 1'b0, 1'b0, 16'h8500);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0072);
        check({14'h0, high_alarm_flag, low_alarm_flag}, 16'h0002);
        pulse(2);
        convert(1'b1, 1'b0, 1'b0, 16'h3EFF);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0071);
        pulse(2);
        convert(1'b1, 1'b0, 1'b0, 16'h84FF);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0070);
        // 8-bit result: the alarm still looks at the high byte alone
        convert(1'b0, 1'b0, 1'b0, 16'h85FF);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0072);
        host_u.write(10'h210, 8'h00);
        host_u.write(10'h212, 8'h00);
        host_u.read(10'h210, d);
        check({8'h00, d}, 16'h0003);
        host_u.read(10'h212, d);
        check({8'h00, d}, 16'h0001);
        @(posedge sys_clk);
        mission_active <= 1'b0;
        host_u.write(10'h210, 8'h00);
        @(posedge sys_clk);
        mission_active <= 1'b1;
        pulse(2);
        convert(1'b1, 1'b0, 1'b0, 16'hFF00);
        convert(1'b1, 1'b0, 1'b0, 16'h0000);
        host_u.read(10'h214, d);
        check({8'h00, d}, 16'h0070);
        @(posedge sys_clk);
        mission_active <= 1'b0;
        // idle device: oscillator is stopped to save power
        host_u.write(10'h212, 8'h00);
        host_u.read(10'h212, d);
        check({15'h0, oscillator_enable}, 16'h0000);
        // mid-run reset with a result held and the oscillator running
        convert(1'b1, 1'b0, 1'b0, 16'h5460);
        pulse(0);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check(log_sample, 16'h0000);
        check({2'h0, sample_rate}, 16'h0001);
        check({12'h000, oscillator_enable, sample_unit_seconds, high_alarm_flag,
               low_alarm_flag}, 16'h0000);
        check({8'h00, rd_data}, 16'h0000);
        nrst <= 1'b1;
        host_u.read(10'h20D, d);
        check({8'h00, d}, 16'h0000);
        host_u.read(10'h209, d);
        check({8'h00, d}, 16'h0000);
        summarize();
    end
endmodule
